/* inc/mtrf_pkg.sv */
// Purpose: Shared constants for the transmit outcome / receive filter block
// Assumes: APB with 32-bit data, 50 MHz ref_clk
// Notes:   Offsets are byte addresses
package mtrf_pkg;
    localparam logic [7:0]  TX_OUTCOME_OFS  = 8'h04;
    localparam logic [7:0]  RX_CONFIG_OFS   = 8'h0C;
    localparam logic [7:0]  TX_CMD_OFS      = 8'h10;
    localparam logic [7:0]  STATION_LO_OFS  = 8'h14;
    localparam logic [7:0]  STATION_HI_OFS  = 8'h18;
    localparam logic [7:0]  COLL_COUNT_OFS  = 8'h1C;
    // Transmit outcome bit positions
    localparam int TX_OK_BIT      = 0;
    localparam int COLLIDED_BIT   = 2;
    localparam int EXCESS_BIT     = 3;
    localparam int CARRIER_BIT    = 4;
    localparam int STARVED_BIT    = 5;
    localparam int HEARTBEAT_BIT  = 6;
    localparam int LATE_COLL_BIT  = 7;
    // Receive config bit positions
    localparam int KEEP_ERR_BIT   = 0;
    localparam int RUNT_BIT       = 1;
    localparam int BCAST_BIT      = 2;
    localparam int MCAST_BIT      = 3;
    localparam int ALLUNI_BIT     = 4;
    localparam int CHECK_ONLY_BIT = 5;
    localparam logic [7:0] TX_OUTCOME_MASK = 8'hFD;
    localparam logic [7:0] RX_CONFIG_MASK  = 8'h3F;
    localparam logic [7:0] RX_CONFIG_RST   = 8'h00;
    localparam logic [4:0] MAX_ATTEMPTS    = 5'h10;
    localparam logic [10:0] MIN_LEN        = 11'h040;
    localparam logic [10:0] RUNT_MIN_LEN   = 11'h008;
    // Timing
    localparam int CLK_MHZ          = 50;
    localparam int HB_WINDOW_NS     = 6400;
    localparam int SLOT_TIME_NS     = 51200;
    localparam int HB_WINDOW_CYC    = (HB_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int SLOT_TIME_CYC    = (SLOT_TIME_NS * CLK_MHZ) / 1000;
endpackage

/* hdl/mtrf_top.sv */
// Purpose: Per-packet transmit outcome flags and receive accept filter
// Assumes: Event inputs come from same-clock MAC logic, one-cycle pulses
// Notes:   Backoff, DMA, tallies and hash array live outside
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
module mtrf_top (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        txCollision,
    input  wire logic        txCarrierLost,
    input  wire logic        txFifoEmpty,
    input  wire logic        txBusGranted,
    input  wire logic        txDone,
    input  wire logic        heartbeatSeen,
    input  wire logic        rxEnd,
    input  wire logic [47:0] rxDestAddr,
    input  wire logic [10:0] rxLength,
    input  wire logic        rxCrcErr,
    input  wire logic        rxAlignErr,
    input  wire logic        rxHashHit,
    output logic             txActive,
    output logic             txAbort,
    output logic             txReschedule,
    output logic             rxAccept,
    output logic             rxStore,
    output logic             rxMissedInc
);
    typedef enum logic [1:0] {
        MTRF_IDLE = 2'b00,
        MTRF_SEND = 2'b01,
        MTRF_GAP  = 2'b10
    } mtrf_state_e;

    mtrf_state_e state_r;
    logic [7:0]  txOutcome_r;
    logic [7:0]  rxConfig_r;
    logic [47:0] stationAddr_r;
    logic [4:0]  clashCount_r;
    logic [15:0] timer_r;
    logic        hbSeen_r;
    logic        apbAccess;
    logic        apbWrite;
    logic        txStart;
    logic        endSend;
    logic        excessHit;
    logic        lateColl;
    logic [7:0]  outcome_nxt;

    assign apbAccess = psel && penable && pready;
    assign apbWrite  = apbAccess && pwrite;
    assign txStart   = apbWrite && paddr == mtrf_pkg::TX_CMD_OFS && pwdata[0]
                       && state_r == MTRF_IDLE;
    assign excessHit = txCollision
                       && (clashCount_r + 5'h01) == mtrf_pkg::MAX_ATTEMPTS;
    assign lateColl  = txCollision
                       && timer_r >= 16'(mtrf_pkg::SLOT_TIME_CYC);
    assign endSend   = state_r == MTRF_SEND && (txDone || excessHit
                       || (txFifoEmpty && !txBusGranted));

    // One APB wait state: access phase always answered on its second cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready
                       && paddr != mtrf_pkg::TX_OUTCOME_OFS
                       && paddr != mtrf_pkg::RX_CONFIG_OFS
                       && paddr != mtrf_pkg::TX_CMD_OFS
                       && paddr != mtrf_pkg::STATION_LO_OFS
                       && paddr != mtrf_pkg::STATION_HI_OFS
                       && paddr != mtrf_pkg::COLL_COUNT_OFS;
        end
    end

    // Read data registered in the first access cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready && !pwrite) begin
            case (paddr)
                mtrf_pkg::TX_OUTCOME_OFS: prdata <= {24'h0, txOutcome_r};
                mtrf_pkg::TX_CMD_OFS:     prdata <= {31'h0, txActive};
                mtrf_pkg::STATION_LO_OFS: prdata <= stationAddr_r[31:0];
                mtrf_pkg::STATION_HI_OFS:
                    prdata <= {16'h0, stationAddr_r[47:32]};
                mtrf_pkg::COLL_COUNT_OFS: prdata <= {27'h0, clashCount_r};
                default:                  prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxConfig_r <= mtrf_pkg::RX_CONFIG_RST;
        end else if (apbWrite && paddr == mtrf_pkg::RX_CONFIG_OFS) begin
            rxConfig_r <= pwdata[7:0] & mtrf_pkg::RX_CONFIG_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stationAddr_r <= 48'h0000_0000_0000;
        end else if (apbWrite && paddr == mtrf_pkg::STATION_LO_OFS) begin
            stationAddr_r[31:0] <= pwdata;
        end else if (apbWrite && paddr == mtrf_pkg::STATION_HI_OFS) begin
            stationAddr_r[47:32] <= pwdata[15:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= MTRF_IDLE;
        end else begin
            case (state_r)
                MTRF_IDLE: if (txStart) state_r <= MTRF_SEND;
                MTRF_SEND: if (endSend) state_r <= MTRF_GAP;
                MTRF_GAP:
                    if (timer_r >= 16'(mtrf_pkg::HB_WINDOW_CYC - 1))
                        state_r <= MTRF_IDLE;
                default: state_r <= MTRF_IDLE;
            endcase
        end
    end

    // Counts slot time while sending, heartbeat window in the gap;
    // restarts per attempt so late collisions are per attempt
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer_r <= 16'h0000;
        end else if (txStart || endSend || (state_r == MTRF_SEND
                     && txCollision)) begin
            timer_r <= 16'h0000;
        end else if (state_r != MTRF_IDLE && timer_r != 16'hFFFF) begin
            timer_r <= timer_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hbSeen_r <= 1'b0;
        end else if (endSend) begin
            hbSeen_r <= 1'b0;
        end else if (state_r == MTRF_GAP && heartbeatSeen) begin
            hbSeen_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clashCount_r <= 5'h00;
        end else if (txStart) begin
            clashCount_r <= 5'h00;
        end else if (state_r == MTRF_SEND && txCollision
                     && clashCount_r != mtrf_pkg::MAX_ATTEMPTS) begin
            clashCount_r <= clashCount_r + 5'h01;
        end
    end

    always_comb begin
        outcome_nxt = txOutcome_r;
        if (state_r == MTRF_SEND) begin
            if (txCollision)
                outcome_nxt[mtrf_pkg::COLLIDED_BIT] = 1'b1;
            if (excessHit)
                outcome_nxt[mtrf_pkg::EXCESS_BIT] = 1'b1;
            if (txCarrierLost)
                outcome_nxt[mtrf_pkg::CARRIER_BIT] = 1'b1;
            if (txFifoEmpty && !txBusGranted)
                outcome_nxt[mtrf_pkg::STARVED_BIT] = 1'b1;
            if (lateColl)
                outcome_nxt[mtrf_pkg::LATE_COLL_BIT] = 1'b1;
            if (endSend)
                outcome_nxt[mtrf_pkg::TX_OK_BIT] =
                    !outcome_nxt[mtrf_pkg::EXCESS_BIT]
                    && !outcome_nxt[mtrf_pkg::STARVED_BIT];
        end
        if (state_r == MTRF_GAP
            && timer_r >= 16'(mtrf_pkg::HB_WINDOW_CYC - 1)
            && !hbSeen_r && !heartbeatSeen)
            outcome_nxt[mtrf_pkg::HEARTBEAT_BIT] = 1'b1;
        if (txStart)
            outcome_nxt = 8'h00;
        outcome_nxt = outcome_nxt & mtrf_pkg::TX_OUTCOME_MASK;
    end

    // Zero after reset; software must not trust it before a first send
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txOutcome_r <= 8'h00;
        end else begin
            txOutcome_r <= outcome_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txActive     <= 1'b0;
            txAbort      <= 1'b0;
            txReschedule <= 1'b0;
        end else begin
            txActive     <= (state_r == MTRF_IDLE && txStart)
                            || (state_r == MTRF_SEND && !endSend);
            txAbort      <= state_r == MTRF_SEND && (excessHit
                            || (txFifoEmpty && !txBusGranted));
            txReschedule <= state_r == MTRF_SEND && txCollision
                            && !excessHit;
        end
    end

    // Receive acceptance decision on the packet's final cycle
    logic isBcast;
    logic isMcast;
    logic addrOk;
    logic errOk;
    logic lenOk;
    assign isBcast = &rxDestAddr;
    assign isMcast = rxDestAddr[40] && !isBcast;
    assign addrOk  = (isBcast && rxConfig_r[mtrf_pkg::BCAST_BIT])
                  || (isMcast && rxConfig_r[mtrf_pkg::MCAST_BIT]
                      && rxHashHit)
                  || (!rxDestAddr[40]
                      && (rxConfig_r[mtrf_pkg::ALLUNI_BIT]
                          || rxDestAddr == stationAddr_r));
    assign errOk   = !(rxCrcErr || rxAlignErr)
                     || rxConfig_r[mtrf_pkg::KEEP_ERR_BIT];
    assign lenOk   = rxLength >= mtrf_pkg::MIN_LEN
                     || (rxConfig_r[mtrf_pkg::RUNT_BIT]
                         && rxLength >= mtrf_pkg::RUNT_MIN_LEN);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxAccept    <= 1'b0;
            rxStore     <= 1'b0;
            rxMissedInc <= 1'b0;
        end else begin
            rxAccept    <= rxEnd && addrOk && errOk && lenOk;
            rxStore     <= rxEnd && addrOk && errOk && lenOk
                           && !rxConfig_r[mtrf_pkg::CHECK_ONLY_BIT];
            rxMissedInc <= rxEnd && addrOk && !rxCrcErr && !rxAlignErr
                           && lenOk
                           && rxConfig_r[mtrf_pkg::CHECK_ONLY_BIT];
        end
    end

    sequence s_start;
        txStart;
    endsequence
    a_outcome_cleared: assert property (@(posedge ref_clk) disable iff (srst)
        s_start |=> txOutcome_r == 8'h00)
        else $error("outcome not cleared at start");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
        txOutcome_r[1] == 1'b0 && rxConfig_r[7:6] == 2'b00)
        else $error("reserved bit set");
    a_ok_exclusive: assert property (@(posedge ref_clk) disable iff (srst)
        txOutcome_r[0] |-> !txOutcome_r[3] && !txOutcome_r[5])
        else $error("tx_ok with abort");
    a_excess_abort: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_SEND && excessHit |=> txAbort && txOutcome_r[3])
        else $error("excess collisions not aborted");
    a_starve_abort: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_SEND && txFifoEmpty && !txBusGranted
        |=> txAbort && txOutcome_r[5] && state_r == MTRF_GAP)
        else $error("underrun not aborted");
    a_carrier_cont: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_SEND && txCarrierLost && !endSend
        |=> txOutcome_r[4] && txActive && !txAbort)
        else $error("carrier loss mishandled");
    a_collide_flag: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_SEND && txCollision |=> txOutcome_r[2])
        else $error("collision flag missing");
    a_monitor_nostore: assert property (@(posedge ref_clk) disable iff (srst)
        rxConfig_r[5] && $stable(rxConfig_r) |=> !rxStore)
        else $error("stored in check-only mode");
    a_txok_set: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_SEND && txDone && !excessHit && txBusGranted
        && !txOutcome_r[3] && !txOutcome_r[5] |=> txOutcome_r[0])
        else $error("tx_ok not set after clean send");
    a_late_flag: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_SEND && lateColl
        |=> txOutcome_r[7] && (txReschedule || txAbort))
        else $error("late collision mishandled");
    a_hb_missing: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_GAP && timer_r >= 16'(mtrf_pkg::HB_WINDOW_CYC - 1)
        && !hbSeen_r && !heartbeatSeen |=> txOutcome_r[6])
        else $error("missing heartbeat not flagged");
    a_hb_present: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == MTRF_GAP && hbSeen_r |=> !txOutcome_r[6])
        else $error("heartbeat flag set despite heartbeat");
    a_err_reject: assert property (@(posedge ref_clk) disable iff (srst)
        rxEnd && (rxCrcErr || rxAlignErr) && !rxConfig_r[0] |=> !rxAccept)
        else $error("errored packet accepted");
    a_tiny_reject: assert property (@(posedge ref_clk) disable iff (srst)
        rxEnd && rxLength < mtrf_pkg::RUNT_MIN_LEN |=> !rxAccept)
        else $error("packet under runt minimum accepted");
endmodule // mtrf_top

/* verif/mtrf_medium.sv */
// Purpose: Medium model: collisions, carrier loss, frame end, heartbeat
// Assumes: One-cycle event pulses on ref_clk
// Notes:   A collision restarts the attempt timer, like a retry
`timescale 1ns/100ps
module mtrf_medium (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        txActive,
    input  wire logic [4:0]  nColl,
    input  wire logic [11:0] collAt,
    input  wire logic        dropCar,
    input  wire logic        hbOn,
    output logic             txCollision,
    output logic             txCarrierLost,
    output logic             txDone,
    output logic             heartbeatSeen
);
    logic [11:0] cnt_r;
    logic [4:0]  left_r;
    logic [3:0]  gap_r;
    logic        act_r;
    always_ff @(posedge ref_clk) begin
        txCollision   <= 1'h0;
        txCarrierLost <= 1'h0;
        txDone        <= 1'h0;
        cnt_r         <= cnt_r + 12'h001;
        if (srst || !txActive) begin
            cnt_r  <= 12'h000;
            left_r <= nColl;
        end else if (left_r != 5'h00 && cnt_r == collAt) begin
            txCollision <= 1'h1;
            left_r      <= left_r - 5'h01;
            cnt_r       <= 12'h000;
        end else begin
            txCarrierLost <= dropCar && cnt_r == 12'h002;
            // Frame only ends once all ordered collisions are spent
            txDone        <= left_r == 5'h00 && cnt_r == 12'h064;
        end
    end
    always_ff @(posedge ref_clk) begin
        act_r         <= txActive;
        heartbeatSeen <= hbOn && gap_r == 4'hA;
        if (srst)
            gap_r <= 4'h0;
        else if (act_r && !txActive)
            gap_r <= 4'h1;
        else if (gap_r != 4'h0)
            gap_r <= gap_r + 4'h1;
    end
endmodule // mtrf_medium

/* verif/tb_top.sv */
// Purpose: Self-checking bench for mtrf_top
// Assumes: Medium model makes tx events; bench drives APB and rx
// Notes:   Outcome is never read before a first send, content zero after reset
`timescale 1ns/100ps
module tb_top;
    logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed, q;
    logic        txCollision, txCarrierLost, txFifoEmpty, txBusGranted;
    logic        txDone, heartbeatSeen, rxEnd, rxCrcErr, rxAlignErr;
    logic        rxHashHit, txActive, txAbort, txReschedule, rxAccept;
    logic        rxStore, rxMissedInc, dropCar, hbOn, err;
    logic [47:0] rxDestAddr, station;
    logic [10:0] rxLength;
    logic [4:0]  nColl;
    logic [11:0] collAt;
    int          mismatches, checkCount, aborts, resched;
    mtrf_top i_mtrf_top (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .txCollision, .txCarrierLost,
        .txFifoEmpty, .txBusGranted, .txDone, .heartbeatSeen, .rxEnd,
        .rxDestAddr, .rxLength, .rxCrcErr, .rxAlignErr, .rxHashHit,
        .txActive, .txAbort, .txReschedule, .rxAccept, .rxStore,
        .rxMissedInc);
    mtrf_medium i_mtrf_medium (.ref_clk, .srst, .txActive, .nColl, .collAt,
        .dropCar, .hbOn, .txCollision, .txCarrierLost, .txDone,
        .heartbeatSeen);
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end
    always @(posedge ref_clk) begin
        if (txAbort === 1'h1) aborts++;
        if (txReschedule === 1'h1) resched++;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Holds the request until pready is seen high at a rising edge, giving up after 50 edges
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        q = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [7:0] txExp(int nc, logic car, hb, lt, un);
        logic [7:0] f;
        f = 8'h00;
        f[mtrf_pkg::TX_OK_BIT] = nc < 16 && !un;
        f[mtrf_pkg::COLLIDED_BIT] = nc > 0;
        f[mtrf_pkg::EXCESS_BIT] = nc >= 16;
        f[mtrf_pkg::CARRIER_BIT] = car;
        f[mtrf_pkg::STARVED_BIT] = un;
        f[mtrf_pkg::HEARTBEAT_BIT] = !hb;
        f[mtrf_pkg::LATE_COLL_BIT] = lt;
        return f;
    endfunction
    task automatic send(input int nc, at, input logic car, hb, lt, un);
        int n;
        nColl  <= nc[4:0];
        collAt <= at[11:0];
        dropCar <= car;
        hbOn   <= hb;
        apb(1'h1, mtrf_pkg::TX_CMD_OFS, 32'h1);
        aborts = 0;
        resched = 0;
        for (n = 0; n < 9 && txActive !== 1'h1; n++) @(posedge ref_clk);
        if (un) begin
            repeat (3) @(posedge ref_clk);
            txFifoEmpty  <= 1'h1;
            txBusGranted <= 1'h0;
            repeat (2) @(posedge ref_clk);
            txFifoEmpty  <= 1'h0;
            txBusGranted <= 1'h1;
        end
        for (n = 0; n < 4000 && txActive === 1'h1; n++) @(posedge ref_clk);
        repeat (330) @(posedge ref_clk);
        apb(1'h0, mtrf_pkg::TX_OUTCOME_OFS, 32'h0);
        chk("outcome", q, {24'h0, txExp(nc, car, hb, lt, un)});
        apb(1'h0, mtrf_pkg::COLL_COUNT_OFS, 32'h0);
        chk("collisions", q, 32'(nc));
        chk("aborts", 32'(aborts), 32'(nc >= 16 || un));
        chk("reschedules", 32'(resched), 32'(nc >= 16 ? 15 : nc));
    endtask
    function automatic logic [2:0] rxExp(logic [7:0] c, logic [47:0] d,
                                         logic [10:0] n, logic bad, hh);
        logic m, ok;
        if (d === '1) m = c[mtrf_pkg::BCAST_BIT];
        else if (d[40]) m = c[mtrf_pkg::MCAST_BIT] && hh;
        else m = c[mtrf_pkg::ALLUNI_BIT] || d === station;
        ok = m && (!bad || c[mtrf_pkg::KEEP_ERR_BIT]);
        if (n < mtrf_pkg::MIN_LEN)
            ok = ok && c[mtrf_pkg::RUNT_BIT] && n >= mtrf_pkg::RUNT_MIN_LEN;
        m = c[mtrf_pkg::CHECK_ONLY_BIT];
        return {ok && m && !bad, ok && !m, ok};
    endfunction
    task automatic rxOne(input logic [7:0] c, input logic fh);
        logic [31:0] r, a, b;
        logic [47:0] d;
        logic [10:0] n;
        logic [2:0]  e, s;
        logic        m;
        r = rnd();
        a = rnd();
        b = rnd();
        d = {b[15:9], ~r[0], b[7:0], a};
        if (r[1:0] == 2'h0) d = '1;
        if (r[1:0] == 2'h1) d = station;
        case (r[4:2])
            3'h0: n = 11'h007;
            3'h1: n = 11'h008;
            3'h2: n = 11'h03F;
            3'h3: n = 11'h040;
            default: n = 11'h040 + {1'h0, a[9:0]};
        endcase
        // Hash hit kept off for broadcast, whose class is then unambiguous
        m = (r[7] || fh) && d !== '1;
        e = rxExp(c, d, n, r[5], m);
        @(posedge ref_clk);
        rxEnd      <= 1'h1;
        rxDestAddr <= d;
        rxLength   <= n;
        rxCrcErr   <= r[5];
        rxAlignErr <= r[5] & r[6];
        rxHashHit  <= m;
        @(posedge ref_clk);
        rxEnd <= 1'h0;
        #1;
        s = {rxMissedInc, rxStore, rxAccept};
        chk("rx", {29'h0, s}, {29'h0, e});
    endtask
    initial begin
        int i;
        logic [7:0] c;
        {psel, penable, pwrite, paddr, pwdata, txFifoEmpty} = '0;
        {rxEnd, rxDestAddr, rxLength, rxCrcErr, rxAlignErr, rxHashHit} = '0;
        {nColl, collAt, dropCar, hbOn} = '0;
        txBusGranted = 1'h1;
        srst = 1'h1;
        seed = 32'h00008189;
        repeat (16) @(posedge ref_clk);
        srst <= 1'h0;
        apb(1'h0, 8'h30, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", q, 32'h0);
        send(0, 4, 1'h0, 1'h1, 1'h0, 1'h0);
        send(2, 4, 1'h1, 1'h0, 1'h0, 1'h0);
        send(16, 4, 1'h0, 1'h1, 1'h0, 1'h0);
        send(0, 4, 1'h0, 1'h1, 1'h0, 1'h1);
        send(1, 2600, 1'h0, 1'h1, 1'h1, 1'h0);
        send(0, 4, 1'h0, 1'h1, 1'h0, 1'h0);
        apb(1'h1, mtrf_pkg::TX_OUTCOME_OFS, 32'hFF);
        apb(1'h0, mtrf_pkg::TX_OUTCOME_OFS, 32'h0);
        chk("outcome ro", q, 32'h1);
        q = rnd();
        station = {q[15:9], 1'h0, q[7:0], rnd()};
        apb(1'h1, mtrf_pkg::STATION_LO_OFS, station[31:0]);
        apb(1'h1, mtrf_pkg::STATION_HI_OFS, {16'h0, station[47:32]});
        c = 8'h1C;
        apb(1'h1, mtrf_pkg::RX_CONFIG_OFS, {24'h0, c});
        for (i = 0; i < 8; i++) rxOne(c, 1'h1);
        for (i = 0; i < 240; i++) begin
            if (i % 8 == 0) begin
                q = rnd();
                c = q[7:0];
                apb(1'h1, mtrf_pkg::RX_CONFIG_OFS, q);
            end
            rxOne(c, 1'h0);
        end
        apb(1'h0, mtrf_pkg::RX_CONFIG_OFS, 32'h0);
        chk("config read", q, 32'h0);
        give_verdict();
    end
endmodule // tb_top
